// >>> logic/ubg_defines.svh
// offsets, field positions, reset values and timing counts of the baud block
`ifndef UBG_DEFINES_SVH
`define UBG_DEFINES_SVH
`define UBG_OFF_BAUD_DIVISOR 8'h00
`define UBG_OFF_CONTROL 8'h04
`define UBG_OFF_TRANSMIT_DATA 8'h08
`define UBG_OFF_RECEIVE_DATA 8'h0C
`define UBG_OFF_STATUS 8'h10
`define UBG_CTRL_HS_BIT 0
`define UBG_CTRL_NINE_BIT 1
`define UBG_STAT_TX_READY_BIT 0
`define UBG_STAT_RX_VALID_BIT 1
`define UBG_DIVISOR_RESET 16'h0000
`define UBG_RXDATA_RESET 9'h000
`define UBG_OVERSAMPLE_LOW 5'h10
`define UBG_OVERSAMPLE_HIGH 5'h04
`define UBG_FIFO_DEPTH 8
`endif

// >>> logic/ubg_pkg.sv
// types shared by the baud generator and data register block
package ubg_pkg;
  typedef struct packed {
    logic valid;
    logic [8:0] data;
  } ubg_char_t;
  typedef struct packed {
    logic [15:0] count;
    logic [4:0] phase;
    logic tick;
    logic bit_tick;
  } ubg_timer_t;
endpackage

// >>> logic/ubg_fifo.sv
// parameterised first-in first-out buffer with valid and ready on both sides
module ubg_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] level;
  } ubg_fifo_state_t;
  ubg_fifo_state_t s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push, pop;

  assign in_ready = (s_q.level != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = s_q.level != '0;
  assign out_data = mem_q[s_q.rd];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  function automatic logic [AW-1:0] ubg_next(input logic [AW-1:0] p);
    ubg_next = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = ubg_next(s_q.wr);
    end
    if (pop) begin
      s_d.rd = ubg_next(s_q.rd);
    end
    s_d.level = s_q.level + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage needs no reset; occupancy guards every read
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[s_q.wr] <= in_data;
    end
  end
endmodule

// >>> logic/ubg_baud_timer.sv
// free-running 16-bit baud timer with oversampling prescale
`include "ubg_defines.svh"
module ubg_baud_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // setup
  input wire logic [15:0] baud_divisor,
  input wire logic high_speed_baud_select,
  input wire logic divisor_written,
  // ticks
  output ubg_pkg::ubg_timer_t timer
);
  import ubg_pkg::*;
  ubg_timer_t s_q, s_d;
  logic [4:0] span;

  assign timer = s_q;
  assign span = high_speed_baud_select ? `UBG_OVERSAMPLE_HIGH : `UBG_OVERSAMPLE_LOW;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.bit_tick = 1'b0;
    if (divisor_written) begin
      s_d.count = '0;
      s_d.phase = '0;
    end else if (s_q.count == baud_divisor) begin
      s_d.count = '0;
      s_d.tick = 1'b1;
      // bit every 16 or 4 ticks
      // at-or-above so a select change mid-count cannot run the phase to wrap
      if (s_q.phase >= span - 5'h01) begin
        s_d.phase = '0;
        s_d.bit_tick = 1'b1;
      end else begin
        s_d.phase = s_q.phase + 5'h01;
      end
    end else begin
      s_d.count = s_q.count + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule

// >>> logic/ubg_top.sv
// baud generator and character data registers of a serial port, AXI4-Lite slave
// Function
// - free-running 16-bit baud timer, software period
// - select low: rate Fcy/(16*(divisor+1))
// - select high: rate Fcy/(4*(divisor+1))
// - divisor write clears timer immediately
// - timer clocked from instruction clock
// - transmit register write-only, upper bits zero
// - ninth transmit bit from bit 8
// - receive register read-only, resets zero
// - ninth received bit in bit 8
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "ubg_defines.svh"
module ubg_top (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // to the shifters
  output logic baud_tick,
  output logic baud_bit_tick,
  output logic high_speed_baud_select,
  output logic nine_bit_mode,
  output ubg_pkg::ubg_char_t tx_char,
  input wire logic tx_char_ready,
  // from the receive shifter
  input wire ubg_pkg::ubg_char_t rx_char
);
  import ubg_pkg::*;

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] baud_divisor;
    logic high_speed_baud_select;
    logic nine_bit_mode;
    logic divisor_written;
    logic [8:0] rx_data;
    logic rx_fresh;
  } ubg_state_t;

  ubg_state_t s_q, s_d;
  ubg_timer_t timer;
  logic fifo_in_valid, fifo_in_ready;
  logic [8:0] fifo_in_data;
  logic wr_fire;
  logic rd_fire;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic ubg_mapped(input logic [7:0] a);
    ubg_mapped = (a == `UBG_OFF_BAUD_DIVISOR) || (a == `UBG_OFF_CONTROL) ||
                 (a == `UBG_OFF_TRANSMIT_DATA) || (a == `UBG_OFF_RECEIVE_DATA) ||
                 (a == `UBG_OFF_STATUS);
  endfunction

  function automatic logic [15:0] ubg_merge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] st);
    ubg_merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction

  // one clock domain; aclk is the instruction clock
  ubg_baud_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .baud_divisor(s_q.baud_divisor),
    .high_speed_baud_select(s_q.high_speed_baud_select),
    .divisor_written(s_q.divisor_written),
    .timer(timer)
  );

  // transmit characters wait here for the shifter
  ubg_fifo #(
    .WIDTH(9),
    .DEPTH(`UBG_FIFO_DEPTH)
  ) u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(tx_char.valid),
    .out_ready(tx_char_ready),
    .out_data(tx_char.data)
  );

  assign baud_tick = timer.tick;
  assign baud_bit_tick = timer.bit_tick;
  assign high_speed_baud_select = s_q.high_speed_baud_select;
  assign nine_bit_mode = s_q.nine_bit_mode;

  // write taken once both halves are held; a full fifo stalls the response
  assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid &&
                   (s_q.aw_addr != `UBG_OFF_TRANSMIT_DATA || fifo_in_ready);
  assign rd_fire = arvalid && !s_q.rvalid;
  assign awready = ce && !s_q.aw_held;
  assign wready = ce && !s_q.w_held;
  assign arready = ce && !s_q.rvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;

  // character plus ninth bit into the fifo
  assign fifo_in_valid = ce && wr_fire && s_q.aw_addr == `UBG_OFF_TRANSMIT_DATA &&
                         s_q.w_strb[0];
  assign fifo_in_data = {s_q.nine_bit_mode & s_q.w_data[8], s_q.w_data[7:0]};

  always_comb begin
    s_d = s_q;
    s_d.divisor_written = 1'b0;
    if (awvalid && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (wr_fire) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = ubg_mapped(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_q.aw_addr)
        `UBG_OFF_BAUD_DIVISOR: begin
          s_d.baud_divisor = ubg_merge(s_q.baud_divisor, s_q.w_data, s_q.w_strb);
          s_d.divisor_written = |s_q.w_strb[1:0];
        end
        `UBG_OFF_CONTROL: begin
          if (s_q.w_strb[0]) begin
            s_d.high_speed_baud_select = s_q.w_data[`UBG_CTRL_HS_BIT];
            s_d.nine_bit_mode = s_q.w_data[`UBG_CTRL_NINE_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    // capture of a new character wins over the read that clears fresh
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = ubg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      s_d.rdata = 32'h0000_0000;
      unique case (araddr)
        `UBG_OFF_BAUD_DIVISOR: s_d.rdata = {16'h0000, s_q.baud_divisor};
        `UBG_OFF_CONTROL: begin
          s_d.rdata[`UBG_CTRL_HS_BIT] = s_q.high_speed_baud_select;
          s_d.rdata[`UBG_CTRL_NINE_BIT] = s_q.nine_bit_mode;
        end
        `UBG_OFF_RECEIVE_DATA: begin
          s_d.rdata = {23'h000000, s_q.rx_data};
          s_d.rx_fresh = 1'b0;
        end
        `UBG_OFF_STATUS: begin
          s_d.rdata[`UBG_STAT_TX_READY_BIT] = fifo_in_ready;
          s_d.rdata[`UBG_STAT_RX_VALID_BIT] = s_q.rx_fresh;
        end
        default: begin
        end
      endcase
    end
    if (rx_char.valid) begin
      s_d.rx_data = {s_q.nine_bit_mode & rx_char.data[8], rx_char.data[7:0]};
      s_d.rx_fresh = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.baud_divisor <= `UBG_DIVISOR_RESET;
      s_q.rx_data <= `UBG_RXDATA_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule

// >>> verification/ubg_top_chk.sv
// checker bound to the baud block top
module ubg_top_chk (
  // clock, reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // shifter side
  input wire logic baud_bit_tick,
  input wire logic high_speed_baud_select,
  input wire ubg_pkg::ubg_char_t tx_char,
  input wire logic tx_char_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import ubg_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  a_ar_once: assert property (arvalid && arready |=> !arready)
    else $error("second read accepted");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_head_kept: assert property (tx_char.valid && !tx_char_ready
    |=> tx_char.valid && $stable(tx_char.data))
    else $error("stalled head changed");
  // four clocks at least between bit ticks in either mode
  a_bit_space: assert property (baud_bit_tick |=> !baud_bit_tick [*3])
    else $error("bit ticks too close");
  cover property (baud_bit_tick && high_speed_baud_select);
  cover property (tx_char.valid && tx_char_ready);
  cover property (rvalid && rdata[8]);
endmodule

bind ubg_top ubg_top_chk u_chk (.aclk, .aresetn, .arvalid, .arready, .rvalid, .rready,
  .rdata, .bvalid, .bready, .bresp, .baud_bit_tick, .high_speed_baud_select, .tx_char,
  .tx_char_ready);

// >>> verification/ubg_peer_model.sv
// shifter stand-in: pops characters, delivers received ones
module ubg_peer_model (
  input wire logic aclk,
  input wire logic stall,
  input wire ubg_pkg::ubg_char_t tx_char,
  output logic tx_char_ready,
  output ubg_pkg::ubg_char_t rx_char
);
  timeunit 1ns;
  timeprecision 1ns;
  import ubg_pkg::*;
  initial rx_char = '0;
  assign tx_char_ready = !stall;
  // stale data inverted so nothing relies on it after the pulse
  task automatic send(input logic [8:0] c);
    @(posedge aclk);
    rx_char <= '{1'b1, c};
    @(posedge aclk);
    rx_char <= '{1'b0, ~c};
  endtask
endmodule

// >>> verification/uart_baud_gen_data_regs_test.sv
// self-checking bench for the baud generator and data registers
module uart_baud_gen_data_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ubg_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stall;
  logic awready, wready, bvalid, arready, rvalid, baud_tick, baud_bit_tick, hs, nine;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  ubg_char_t tx_char, rx_char;
  logic tx_char_ready;
  int n_errors = 0;
  int check_count = 0;
  ubg_top dut (.aclk, .aresetn, .ce(1'b1), .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .baud_tick, .baud_bit_tick, .high_speed_baud_select(hs),
    .nine_bit_mode(nine), .tx_char, .tx_char_ready, .rx_char);
  ubg_peer_model u_peer (.aclk, .stall, .tx_char, .tx_char_ready, .rx_char);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // readies sampled at negedge: inputs only move at posedge
  // slow: response ready raised only once the answer is seen, to stall it
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
                     input bit slow = 1'b0);
    bit fa, fw, fr, fb, fs;
    @(posedge aclk);
    awvalid <= w;
    wvalid <= w;
    bready <= w && !slow;
    arvalid <= !w;
    rready <= !w && !slow;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    do begin
      @(negedge aclk);
      fa = awvalid && awready;
      fw = wvalid && wready;
      fr = arvalid && arready;
      fb = (bready && bvalid) || (rready && rvalid);
      fs = bvalid || rvalid;
      q = rdata;
      r = w ? bresp : rresp;
      @(posedge aclk);
      if (fs && !fb) begin
        bready <= w;
        rready <= !w;
      end
      if (fa) awvalid <= 1'b0;
      if (fw) wvalid <= 1'b0;
      if (fr) arvalid <= 1'b0;
    end while (!fb);
    bready <= 1'b0;
    rready <= 1'b0;
  endtask
  task automatic gap(input bit b, output int g);
    for (int k = 0; k < 2; k++) begin
      g = 0;
      do begin
        @(negedge aclk);
        g++;
      end while (!(b ? baud_bit_tick : baud_tick));
    end
  endtask
  task automatic t_regs();
    bus(0, 8'h0C, 32'h0);
    chk(q, 32'h0);
    bus(1, 8'h0C, 32'h1FF, 1'b1);
    chk(32'(r), 32'h0);
    bus(0, 8'h0C, 32'h0);
    chk(q, 32'h0);
    bus(0, 8'h08, 32'h0, 1'b1);
    chk(q, 32'h0);
    bus(0, 8'h14, 32'h0);
    chk(32'(r), 32'h2);
    $display("register test done");
  endtask
  task automatic t_rate(input bit h);
    int g;
    bus(1, 8'h04, {31'h0, h});
    chk(32'(hs), 32'(h));
    bus(1, 8'h00, 32'h3);
    gap(0, g);
    chk(32'(g), 32'h4);
    gap(1, g);
    chk(32'(g), h ? 32'h10 : 32'h40);
    $display("rate test %0d done", h);
  endtask
  task automatic t_restart();
    int g;
    bus(1, 8'h00, 32'hC7);
    repeat (20) @(posedge aclk);
    bus(1, 8'h00, 32'h2);
    g = 0;
    do begin
      @(negedge aclk);
      g++;
    end while (!baud_tick);
    chk(32'(g < 6), 32'h1);
    gap(0, g);
    chk(32'(g), 32'h3);
    $display("restart test done");
  endtask
  task automatic t_tx();
    int i;
    @(posedge aclk);
    stall <= 1'b1;
    bus(1, 8'h04, 32'h2);
    chk(32'(nine), 32'h1);
    u_peer.send(9'h1C3);
    bus(0, 8'h0C, 32'h0);
    chk(q, 32'h1C3);
    for (i = 0; i < 8; i++) bus(1, 8'h08, 32'h1A5 + i);
    @(negedge aclk);
    chk(32'(tx_char), 32'h3A5);
    bus(0, 8'h10, 32'h0);
    chk(q, 32'h0);
    stall <= 1'b0;
    i = 0;
    while (i < 8) begin
      @(negedge aclk);
      if (tx_char.valid) begin
        chk(32'(tx_char.data), 32'h1A5 + i);
        i++;
      end
    end
    @(negedge aclk);
    chk(32'(tx_char.valid), 32'h0);
    $display("character test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, stall} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_rate(1'b0);
    t_rate(1'b1);
    t_restart();
    t_tx();
    report_and_stop();
  end
endmodule
